/* File: core/dsd_pkg.sv */
// package for the device-specific diagnostic builder: register map, field layout and codes
package dsd_pkg;
    // apb register byte offsets (printed offsets 0x0 and 0x1 are indices, address is four times)
    localparam logic [7:0] IDX_STATUS = 8'h00;
    localparam logic [7:0] IDX_PAYLOAD = 8'h01;
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_PAYLOAD_LO = 8'h04;
    localparam logic [7:0] ADDR_PAYLOAD_HI = 8'h08;
    localparam logic [7:0] ADDR_ERROR = 8'h0C;
    localparam logic [7:0] ADDR_CONTROL = 8'h10;
    localparam logic [7:0] ADDR_TELEGRAM = 8'h14;
    // status byte fields
    localparam int STAT_VALID_BIT = 0;
    localparam int STAT_DELETE_BIT = 1;
    localparam logic [7:0] STAT_RESET = 8'h00;
    localparam logic [7:0] STAT_IGNORED = 8'h03;
    // telegram layout
    localparam int TEL_FIRST = 6;
    localparam int TEL_LAST = 15;
    localparam int TEL_LEN = 10;
    localparam int USER_FIRST = 11;
    localparam int USER_LEN = 5;
    localparam logic [5:0] DEV_LEN_FIELD = 6'b001010;
    localparam logic [1:0] DEV_CODE_FIELD = 2'b00;
    // byte 7 message codes
    localparam logic [7:0] MSG_NONE = 8'h00;
    localparam logic [7:0] MSG_PARAM_LEN = 8'h12;
    localparam logic [7:0] MSG_CFG_LEN = 8'h13;
    localparam logic [7:0] MSG_CFG_ENTRY = 8'h14;
    localparam logic [7:0] MSG_BUF_CALC = 8'h15;
    localparam logic [7:0] MSG_CFG_MISSING = 8'h16;
    localparam logic [7:0] MSG_MISMATCH = 8'h17;
    localparam logic [7:0] MSG_USER_VALID = 8'h40;
    // error register: one flag bit per error, several may be set, highest priority is bit 0
    localparam int ERR_BITS = 6;
    localparam logic [5:0] ERR_RESET = 6'h00;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam int CTRL_ENABLE_BIT = 0;

    // telegram byte stream handed to the link side
    typedef struct packed {
        logic valid;
        logic last;
        logic [3:0] index;
        logic [7:0] data;
    } dsd_byte_s;
endpackage : dsd_pkg

/* File: core/dsd_serializer.sv */
// serializer that walks device-specific telegram bytes 6 to 15 out one per accepted beat
`timescale 1ns/10ps
`default_nettype none
module dsd_serializer (
    input wire logic mclk,
    input wire logic srst,
    input wire logic start,
    input wire logic [79:0] image,
    input wire logic byteReady,
    output dsd_pkg::dsd_byte_s byteOut,
    output logic busy
);
    typedef enum logic [1:0] {
        SER_IDLE = 2'b01,
        SER_SEND = 2'b10
    } dsd_ser_e;

    dsd_ser_e state_reg;
    logic [79:0] shot_reg;
    logic [3:0] index_reg;

    // state and index walk; image is frozen on start so a later write cannot tear it
    always_ff @(posedge mclk) begin
        if (srst) begin
            state_reg <= SER_IDLE;
            index_reg <= 4'h0;
            shot_reg <= 80'h0;
        end else begin
            case (state_reg)
                SER_IDLE: begin
                    if (start) begin
                        state_reg <= SER_SEND;
                        shot_reg <= image;
                        index_reg <= 4'(dsd_pkg::TEL_FIRST);
                    end
                end
                SER_SEND: begin
                    if (byteReady) begin
                        if (index_reg == 4'(dsd_pkg::TEL_LAST)) begin
                            state_reg <= SER_IDLE;
                        end else begin
                            index_reg <= index_reg + 4'h1;
                        end
                    end
                end
                default: state_reg <= SER_IDLE;
            endcase
        end
    end

    // byte select from the frozen image, byte 6 in the low bits
    always_comb begin
        byteOut.valid = (state_reg == SER_SEND);
        byteOut.last = (state_reg == SER_SEND) && (index_reg == 4'(dsd_pkg::TEL_LAST));
        byteOut.index = index_reg;
        byteOut.data = shot_reg[8 * (32'(index_reg) - dsd_pkg::TEL_FIRST) +: 8];
        busy = (state_reg == SER_SEND);
    end

    chk_ser_len: assert property (@(posedge mclk) disable iff (srst)
        (state_reg == SER_IDLE) && start |-> ##1 byteOut.valid && byteOut.index == 4'h6)
        else $error("serializer did not open at byte 6");
endmodule // dsd_serializer
`default_nettype wire

/* File: core/dsd_diag_builder.sv */
// device-specific diagnostic builder: apb registers, release detection, telegram bytes 6 to 15
// Overview of operation
// - device-specific part is always ten bytes, telegram bytes 6 to 15
// - byte 6 bits 0 to 5 carry length pattern 001010
// - byte 6 bits 6 and 7 carry code 00
// - byte 7 reports 12h, 13h, 14h for length and entry errors
// - byte 7 reports 15h, 16h, 17h for buffer, missing and mismatch errors
// - byte 7 is 40h when user diagnostic bytes are valid
// - bytes 11 to 15 carry user bytes after the status byte
// - program may overwrite user bytes; updated contents are forwarded
// - user bytes sit in the image preceded by a status byte
// - status plus five user bytes form a six-byte block at a set base
// - status valid bit rising 0 to 1 is the release trigger
// - a release trigger sends the diagnostic to the master
// - status value 03h is ignored entirely
// - status bit 0 marks user data invalid or valid
// - status bit 1 requests deletion of the diagnostic
// - status bits 2 to 7 are reserved and have no effect; the code only ignores an exact 03h, so 07h is not ignored
// - block bytes 1 to 5 map onto telegram bytes 11 to 15
// - after reset the section is inactive with indicators off
// - diagnostic is sent on master request and on error
// - bytes 0 to 5 carry standard data ahead of this part
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module dsd_diag_builder (
    input wire logic mclk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic masterRequest,
    input wire logic stdDone,
    input wire logic byteReady,
    output dsd_pkg::dsd_byte_s byteOut,
    output logic sendRequest,
    output logic diagActiveLed,
    output logic diagPending
);
    logic [7:0] statusByte_reg;
    logic [39:0] payload_reg;
    logic [5:0] errorFlags_reg;
    logic [1:0] control_reg;
    logic validSeen_reg;
    logic deleteSeen_reg;
    logic armed_reg;
    logic diagValid_reg;
    logic pendingSend_reg;
    logic [5:0] errorPrev_reg;
    logic [79:0] image;
    logic [7:0] msgCode;
    logic apbWrite;
    logic apbRead;
    logic addrOk;
    logic releaseTrig;
    logic deleteTrig;
    logic errorEvent;
    logic serBusy;
    logic startSend;
    logic enabled;

    // map a set of error bits, several may be set, onto the byte 7 code, lowest bit first
    function automatic logic [7:0] err_code(input logic [5:0] e, input logic userValid);
        logic [7:0] c;
        c = userValid ? dsd_pkg::MSG_USER_VALID : dsd_pkg::MSG_NONE;
        if (e[5]) c = dsd_pkg::MSG_MISMATCH;
        if (e[4]) c = dsd_pkg::MSG_CFG_MISSING;
        if (e[3]) c = dsd_pkg::MSG_BUF_CALC;
        if (e[2]) c = dsd_pkg::MSG_CFG_ENTRY;
        if (e[1]) c = dsd_pkg::MSG_CFG_LEN;
        if (e[0]) c = dsd_pkg::MSG_PARAM_LEN;
        return c;
    endfunction

    // a status value counts only when it is not the ignored pattern
    function automatic logic status_usable(input logic [7:0] s);
        return s != dsd_pkg::STAT_IGNORED;
    endfunction

    // apb decode: zero wait states, unmapped addresses answer with an error
    always_comb begin
        addrOk = (paddr == dsd_pkg::ADDR_STATUS) || (paddr == dsd_pkg::ADDR_PAYLOAD_LO) ||
                 (paddr == dsd_pkg::ADDR_PAYLOAD_HI) || (paddr == dsd_pkg::ADDR_ERROR) ||
                 (paddr == dsd_pkg::ADDR_CONTROL) || (paddr == dsd_pkg::ADDR_TELEGRAM);
        apbWrite = psel && penable && pwrite && addrOk;
        apbRead = psel && penable && !pwrite;
        pready = psel && penable;
        pslverr = psel && penable && !addrOk;
    end

    // status byte of the six-byte block; software writes it, reserved bits are stored and only enter the 03h ignore compare
    always_ff @(posedge mclk) begin
        if (srst) begin
            statusByte_reg <= dsd_pkg::STAT_RESET;
        end else if (apbWrite && paddr == dsd_pkg::ADDR_STATUS) begin
            statusByte_reg <= pwdata[7:0];
        end
    end

    // user payload, block bytes 1 to 5; writes may change it at any time
    always_ff @(posedge mclk) begin
        if (srst) begin
            payload_reg <= 40'h0;
        end else if (apbWrite && paddr == dsd_pkg::ADDR_PAYLOAD_LO) begin
            payload_reg[31:0] <= pwdata;
        end else if (apbWrite && paddr == dsd_pkg::ADDR_PAYLOAD_HI) begin
            payload_reg[39:32] <= pwdata[7:0];
        end
    end

    // error flags: firmware sets them by writing ones, clears by writing zeros
    always_ff @(posedge mclk) begin
        if (srst) begin
            errorFlags_reg <= dsd_pkg::ERR_RESET;
        end else if (apbWrite && paddr == dsd_pkg::ADDR_ERROR) begin
            errorFlags_reg <= pwdata[5:0];
        end
    end

    // control: bit 0 enables the fieldbus section, off after reset
    always_ff @(posedge mclk) begin
        if (srst) begin
            control_reg <= dsd_pkg::CTRL_RESET;
        end else if (apbWrite && paddr == dsd_pkg::ADDR_CONTROL) begin
            control_reg <= pwdata[1:0];
        end
    end

    assign enabled = control_reg[dsd_pkg::CTRL_ENABLE_BIT];

    // release detection on the valid bit, reserved bits only count in the whole-byte 03h ignore compare
    always_comb begin
        releaseTrig = enabled && status_usable(statusByte_reg) &&
                      statusByte_reg[dsd_pkg::STAT_VALID_BIT] && !validSeen_reg && armed_reg;
        deleteTrig = enabled && status_usable(statusByte_reg) &&
                     statusByte_reg[dsd_pkg::STAT_DELETE_BIT] && !statusByte_reg[dsd_pkg::STAT_VALID_BIT] &&
                     !deleteSeen_reg;
        errorEvent = enabled && ((errorFlags_reg & ~errorPrev_reg) != 6'h00);
    end

    // edge memory: valid must be seen low before another release is armed; delete acts once per rise
    always_ff @(posedge mclk) begin
        if (srst) begin
            validSeen_reg <= 1'b0;
            armed_reg <= 1'b1;
            deleteSeen_reg <= 1'b0;
            errorPrev_reg <= dsd_pkg::ERR_RESET;
        end else begin
            errorPrev_reg <= errorFlags_reg;
            if (status_usable(statusByte_reg)) begin
                validSeen_reg <= statusByte_reg[dsd_pkg::STAT_VALID_BIT];
                deleteSeen_reg <= statusByte_reg[dsd_pkg::STAT_DELETE_BIT];
                if (releaseTrig) begin
                    armed_reg <= 1'b0;
                end else if (!statusByte_reg[dsd_pkg::STAT_VALID_BIT]) begin
                    armed_reg <= 1'b1;
                end
            end
        end
    end

    // user data validity reported in byte 7; delete withdraws it
    always_ff @(posedge mclk) begin
        if (srst) begin
            diagValid_reg <= 1'b0;
        end else if (releaseTrig) begin
            diagValid_reg <= 1'b1;
        end else if (deleteTrig) begin
            diagValid_reg <= 1'b0;
        end
    end

    // pending send: release, delete, error or master request; set wins over the clear on start
    always_ff @(posedge mclk) begin
        if (srst) begin
            pendingSend_reg <= 1'b0;
        end else if (releaseTrig || deleteTrig || errorEvent || (enabled && masterRequest)) begin
            pendingSend_reg <= 1'b1;
        end else if (startSend) begin
            pendingSend_reg <= 1'b0;
        end
    end

    // request the link to send standard bytes first; our bytes follow once it is done
    assign sendRequest = pendingSend_reg && !serBusy;
    assign startSend = sendRequest && stdDone;

    // telegram image, byte 6 in the low bits
    always_comb begin
        msgCode = err_code(errorFlags_reg, diagValid_reg);
        image = {payload_reg,
                 24'h000000,
                 msgCode,
                 dsd_pkg::DEV_CODE_FIELD,
                 dsd_pkg::DEV_LEN_FIELD};
    end

    // read mux from live registers
    always_comb begin
        prdata = 32'h00000000;
        if (apbRead) begin
            case (paddr)
                dsd_pkg::ADDR_STATUS: prdata = {24'h000000, statusByte_reg};
                dsd_pkg::ADDR_PAYLOAD_LO: prdata = payload_reg[31:0];
                dsd_pkg::ADDR_PAYLOAD_HI: prdata = {24'h000000, payload_reg[39:32]};
                dsd_pkg::ADDR_ERROR: prdata = {26'h0, errorFlags_reg};
                dsd_pkg::ADDR_CONTROL: prdata = {30'h0, control_reg};
                dsd_pkg::ADDR_TELEGRAM: prdata = {14'h0, pendingSend_reg, diagValid_reg, image[15:8],
                                                  image[7:0]};
                default: prdata = 32'h00000000;
            endcase
        end
    end

    // indicator outputs follow the section state
    assign diagActiveLed = enabled && diagValid_reg;
    assign diagPending = pendingSend_reg;

    dsd_serializer u_ser (
        .mclk(mclk),
        .srst(srst),
        .start(startSend),
        .image(image),
        .byteReady(byteReady),
        .byteOut(byteOut),
        .busy(serBusy)
    );

    // telegram field and byte 7 code checks
    chk_len_field: assert property (@(posedge mclk) disable iff (srst)
        image[7:0] == 8'h0A)
        else $error("length and code byte wrong");
    chk_code_field: assert property (@(posedge mclk) disable iff (srst)
        image[7:6] == 2'b00)
        else $error("code field not zero");
    chk_reserved_zero: assert property (@(posedge mclk) disable iff (srst)
        byteOut.valid && byteOut.index inside {4'h8, 4'h9, 4'hA} |-> byteOut.data == 8'h00)
        else $error("reserved telegram byte not zero");
    chk_param_err: assert property (@(posedge mclk) disable iff (srst)
        errorFlags_reg[0] |-> msgCode == 8'h12)
        else $error("parameter length code wrong");
    chk_cfg_len_err: assert property (@(posedge mclk) disable iff (srst)
        errorFlags_reg[1:0] == 2'b10 |-> msgCode == 8'h13)
        else $error("configuration length code wrong");
    chk_entry_err: assert property (@(posedge mclk) disable iff (srst)
        errorFlags_reg[2:0] == 3'b100 |-> msgCode == 8'h14)
        else $error("configuration entry code wrong");
    chk_buf_err: assert property (@(posedge mclk) disable iff (srst)
        errorFlags_reg[3:0] == 4'h8 |-> msgCode == 8'h15)
        else $error("buffer calculation code wrong");
    chk_missing_err: assert property (@(posedge mclk) disable iff (srst)
        errorFlags_reg[4:0] == 5'h10 |-> msgCode == 8'h16)
        else $error("missing configuration code wrong");
    chk_mismatch_err: assert property (@(posedge mclk) disable iff (srst)
        errorFlags_reg == 6'h20 |-> msgCode == 8'h17)
        else $error("mismatch code wrong");
    chk_valid_code: assert property (@(posedge mclk) disable iff (srst)
        releaseTrig && errorFlags_reg == 6'h00 |=> msgCode == 8'h40)
        else $error("valid user code missing");
    chk_user_code: assert property (@(posedge mclk) disable iff (srst)
        diagValid_reg && errorFlags_reg == 6'h00 |-> msgCode == 8'h40)
        else $error("valid user data not reported");
    chk_no_user_code: assert property (@(posedge mclk) disable iff (srst)
        !diagValid_reg && errorFlags_reg == 6'h00 |-> msgCode == 8'h00)
        else $error("stale valid code reported");
    chk_user_image: assert property (@(posedge mclk) disable iff (srst)
        image[79:40] == payload_reg)
        else $error("user bytes not in telegram bytes 11 to 15");

    // register writes land on the access edge
    chk_payload_low: assert property (@(posedge mclk) disable iff (srst)
        apbWrite && paddr == dsd_pkg::ADDR_PAYLOAD_LO |=> payload_reg[31:0] == $past(pwdata))
        else $error("payload low word not written");
    chk_payload_high: assert property (@(posedge mclk) disable iff (srst)
        apbWrite && paddr == dsd_pkg::ADDR_PAYLOAD_HI |=> payload_reg[39:32] == $past(pwdata[7:0]))
        else $error("payload high byte not written");
    chk_status_store: assert property (@(posedge mclk) disable iff (srst)
        apbWrite && paddr == dsd_pkg::ADDR_STATUS |=> statusByte_reg == $past(pwdata[7:0]))
        else $error("status byte not written");

    // release, delete and send bookkeeping
    chk_ignore_three: assert property (@(posedge mclk) disable iff (srst)
        statusByte_reg == 8'h03 |-> !releaseTrig && !deleteTrig)
        else $error("status 03h not ignored");
    chk_release_valid: assert property (@(posedge mclk) disable iff (srst)
        releaseTrig |=> diagValid_reg)
        else $error("release did not mark user data valid");
    chk_release_send: assert property (@(posedge mclk) disable iff (srst)
        releaseTrig |=> pendingSend_reg)
        else $error("release did not request a send");
    chk_no_retrigger: assert property (@(posedge mclk) disable iff (srst)
        releaseTrig ##1 statusByte_reg[0] [*2] |-> !releaseTrig)
        else $error("release retriggered without valid falling");
    chk_rearm_wait: assert property (@(posedge mclk) disable iff (srst)
        releaseTrig |=> !armed_reg)
        else $error("release left the trigger armed");
    chk_delete_once: assert property (@(posedge mclk) disable iff (srst)
        deleteTrig |=> !deleteTrig)
        else $error("delete acted twice on one request");
    chk_delete_clears: assert property (@(posedge mclk) disable iff (srst)
        deleteTrig |=> !diagValid_reg)
        else $error("delete left user data valid");
    chk_error_send: assert property (@(posedge mclk) disable iff (srst)
        errorEvent |=> pendingSend_reg)
        else $error("error did not request a send");
    chk_master_send: assert property (@(posedge mclk) disable iff (srst)
        enabled && masterRequest |=> pendingSend_reg)
        else $error("master request did not request a send");
    chk_pending_clear: assert property (@(posedge mclk) disable iff (srst)
        startSend && !(releaseTrig || deleteTrig || errorEvent || (enabled && masterRequest)) |=> !pendingSend_reg)
        else $error("pending send not cleared on start");
    chk_off_quiet: assert property (@(posedge mclk) disable iff (srst)
        !enabled |-> !releaseTrig && !deleteTrig && !errorEvent && !diagActiveLed)
        else $error("disabled section still active");
    chk_off_reset: assert property (@(posedge mclk)
        $fell(srst) |-> !diagActiveLed && !sendRequest)
        else $error("section active after reset");

    // serializer framing seen from the link side
    chk_busy_no_req: assert property (@(posedge mclk) disable iff (srst)
        serBusy |-> !sendRequest)
        else $error("send requested while bytes still going out");
    chk_frame_start: assert property (@(posedge mclk) disable iff (srst)
        startSend |=> byteOut.valid && byteOut.index == 4'h6 && byteOut.data == 8'h0A)
        else $error("telegram did not open with byte 6");
    chk_frame_last: assert property (@(posedge mclk) disable iff (srst)
        byteOut.valid && byteOut.last |-> byteOut.index == 4'hF)
        else $error("last flag not on byte 15");

    // scenario covers
    cov_release: cover property (@(posedge mclk) disable iff (srst) releaseTrig ##[1:60] byteOut.last);
    cov_delete: cover property (@(posedge mclk) disable iff (srst) deleteTrig);
    cov_error: cover property (@(posedge mclk) disable iff (srst) errorEvent ##[1:30] byteOut.last);
    cov_ignored: cover property (@(posedge mclk) disable iff (srst) enabled && statusByte_reg == 8'h03);
    cov_master: cover property (@(posedge mclk) disable iff (srst) enabled && masterRequest ##[1:40] byteOut.last);
endmodule // dsd_diag_builder
`default_nettype wire

/* File: tb/dsd_link_model.sv */
// link-side partner: collects device-specific telegram bytes and can stall between beats
`timescale 1ns/10ps
`default_nettype none
module dsd_link_model (
    input wire logic mclk,
    input wire logic srst,
    input wire dsd_pkg::dsd_byte_s byteOut,
    input wire logic sendRequest,
    input wire logic slow,
    output logic stdDone,
    output logic byteReady,
    output logic [79:0] frame,
    output int nBytes,
    output logic sawLast
);
    logic [1:0] phase;

    // standard bytes go out first, then device bytes are taken one beat at a time
    always_ff @(posedge mclk) begin
        if (srst) begin
            stdDone <= 1'h0;
            byteReady <= 1'h0;
            nBytes <= 0;
            sawLast <= 1'h0;
            phase <= 2'h0;
            frame <= '1;
        end else begin
            phase <= phase + 2'h1;
            stdDone <= sendRequest;
            byteReady <= slow ? phase[1] : 1'h1;
            // stale bytes are poisoned so a missing beat shows
            if (sendRequest) begin
                frame <= '1;
                sawLast <= 1'h0;
            end
            if (byteOut.valid && byteReady) begin
                frame[8 * (int'(byteOut.index) - 6) +: 8] <= byteOut.data;
                nBytes <= nBytes + 1;
                sawLast <= byteOut.last;
            end
        end
    end
endmodule // dsd_link_model
`default_nettype wire

/* File: tb/tb_dsd_diag_builder.sv */
// testbench for the device-specific diagnostic builder with apb master and link partner
`timescale 1ns/10ps
`default_nettype none
module tb_dsd_diag_builder;
    logic mclk, srst, psel, penable, pwrite, pready, pslverr, masterRequest;
    logic stdDone, byteReady, slow, sendRequest, diagActiveLed, diagPending, err, sawLast;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [79:0] frame;
    dsd_pkg::dsd_byte_s byteOut;
    int nBytes;
    int n_mismatch = 0;
    int total_checks = 0;
    int cycles = 0;
    int base = 0;

    dsd_diag_builder u_dsd_diag_builder (.mclk(mclk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .masterRequest(masterRequest), .stdDone(stdDone), .byteReady(byteReady),
        .byteOut(byteOut), .sendRequest(sendRequest), .diagActiveLed(diagActiveLed),
        .diagPending(diagPending));
    dsd_link_model u_dsd_link_model (.mclk(mclk), .srst(srst), .byteOut(byteOut),
        .sendRequest(sendRequest), .slow(slow), .stdDone(stdDone), .byteReady(byteReady),
        .frame(frame), .nBytes(nBytes), .sawLast(sawLast));

    // free-running clock
    initial begin
        mclk = 1'h0;
        forever #5 mclk = ~mclk;
    end

    // hang guard
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            complete_run();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one apb transfer: setup, then access until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'h1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    // wait for a whole telegram at the partner and compare it
    task automatic waitSend(input logic [7:0] code, input logic [39:0] user);
        while (nBytes < base + 10) begin
            @(posedge mclk);
        end
        @(posedge mclk);
        check("byte count", nBytes - base, 10);
        check("byte6", frame[7:0], 8'h0A);
        check("byte7", frame[15:8], code);
        check("bytes8to10", frame[39:16], 24'h0);
        check("user low", frame[71:40], user[31:0]);
        check("user high", frame[79:72], user[39:32]);
        check("last flag", sawLast, 1'h1);
        check("pending clear", diagPending, 1'h0);
        base = nBytes;
    endtask

    // no send may be requested for a while
    task automatic quiet(input string what);
        logic seen;
        seen = 1'h0;
        repeat (30) begin
            @(posedge mclk);
            seen = seen | sendRequest;
        end
        check(what, seen, 1'h0);
    endtask

    task automatic testReset();
        check("led", diagActiveLed, 1'h0);
        check("send", sendRequest, 1'h0);
        check("byte valid", byteOut.valid, 1'h0);
        check("pending", diagPending, 1'h0);
        apb(1'h0, 8'h00, 32'h0);
        check("status", rd, 32'h0);
        apb(1'h0, 8'h14, 32'h0);
        check("telegram", rd, 32'h0000000A);
        apb(1'h0, 8'h40, 32'h0);
        check("unmapped err", err, 1'h1);
        check("unmapped data", rd, 32'h0);
        $display("test reset done");
    endtask

    task automatic testRelease();
        apb(1'h1, 8'h10, 32'h1);
        apb(1'h1, 8'h04, 32'h44332211);
        apb(1'h1, 8'h08, 32'h55);
        slow <= 1'h1;
        apb(1'h1, 8'h00, 32'h1);
        waitSend(8'h40, 40'h5544332211);
        check("led valid", diagActiveLed, 1'h1);
        apb(1'h0, 8'h14, 32'h0);
        check("user valid", rd[16], 1'h1);
        $display("test release done");
    endtask

    task automatic testRetrigger();
        apb(1'h1, 8'h04, 32'hA1B2C3D4);
        apb(1'h1, 8'h00, 32'h1);
        quiet("held valid");
        apb(1'h1, 8'h00, 32'h0);
        quiet("valid low");
        apb(1'h1, 8'h00, 32'hFD);
        waitSend(8'h40, 40'h55A1B2C3D4);
        $display("test retrigger done");
    endtask

    task automatic testIgnored();
        apb(1'h1, 8'h00, 32'h0);
        apb(1'h1, 8'h00, 32'h3);
        quiet("status 03");
        $display("test ignored done");
    endtask

    task automatic testDelete();
        apb(1'h1, 8'h00, 32'h2);
        waitSend(8'h00, 40'h55A1B2C3D4);
        check("led cleared", diagActiveLed, 1'h0);
        $display("test delete done");
    endtask

    // each newly set error outranks the previous one, highest priority last
    task automatic testErrors();
        slow <= 1'h0;
        for (int i = 5; i >= 0; i--) begin
            apb(1'h1, 8'h0C, (32'h3F << i) & 32'h3F);
            waitSend(8'h12 + 8'(i), 40'h55A1B2C3D4);
        end
        @(posedge mclk);
        masterRequest <= 1'h1;
        @(posedge mclk);
        masterRequest <= 1'h0;
        waitSend(8'h12, 40'h55A1B2C3D4);
        $display("test errors done");
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        srst = 1'h1;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        masterRequest = 1'h0;
        slow = 1'h0;
        repeat (3) @(posedge mclk);
        srst <= 1'h0;
        @(posedge mclk);
        testReset();
        testRelease();
        testRetrigger();
        testIgnored();
        testDelete();
        testErrors();
        complete_run();
    end
endmodule // tb_dsd_diag_builder
`default_nettype wire
